// file: rtl/gpp_path.sv
`timescale 1ns/1ps
// Function
// - graphics palette is three 256x8 RAM tables, red, green, blue
// - software reaches the tables through palette read, write and data ports
// - graphics gamma tables act only in high-colour and true-colour formats
// - 15/16 bpp fields are widened to 8 bits, each indexing its table
// - 24 bpp components index their own tables directly
// - at 8 bpp one pixel byte selects one entry of all three tables
// - bypass bit 7 sends high/true-colour pixels straight to the output
// - a separate 256x8x3 video palette adjusts video-window pixels
// - video tables apply only while adjust bit 6 is set
// - brightness byte is signed and added to each video pixel
// - brightness touches video-window pixels only
// - brightness applies whether or not video adjust is on
module gpp_path
   import gpp_pkg::*;
#(
   parameter int FIFO_DEPTH = GPP_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pixel stream in
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic [GPP_PIX_W-1:0] pix_data_i,
   input wire logic pix_video_i,
   // colour stream to the dac
   output logic dac_valid_o,
   input wire logic dac_ready_i,
   output logic [7:0] dac_red_o,
   output logic [7:0] dac_green_o,
   output logic [7:0] dac_blue_o
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] bright;
      logic [7:0] widx;
      logic [7:0] ridx;
      gpp_phase_t wph;
      gpp_phase_t rph;
      logic [7:0] hold_r;
      logic [7:0] hold_g;
      logic s1_v;
      logic s1_video;
      logic s1_use;
      logic [23:0] s1_rgb;
      logic s2_v;
      logic [23:0] s2_rgb;
   } gpp_state_t;

   gpp_state_t st_reg, st_next;

   logic acc, wr_acc, rd_acc, mapped;
   logic tbl_we, gfx_we, vid_we;
   logic [LW-1:0] level;
   logic f_valid, f_ready;
   logic [GPP_PIX_W:0] f_data;
   logic pop, out_adv, s1_load;
   gpp_fmt_t fmt;
   logic bypass, vsel, vadj;
   logic [7:0] dir [3];
   logic [7:0] g_q [3];
   logic [7:0] v_q [3];
   logic [7:0] cg_q [3];
   logic [7:0] cv_q [3];
   logic [7:0] wdat [3];
   logic [7:0] base [3];
   logic [7:0] res [3];
   logic use_tbl;
   logic [1:0] rcomp;
   logic [31:0] status;

   function automatic logic [7:0] gpp_bright(input logic [7:0] v, input logic [7:0] off);
      logic signed [9:0] s;
      s = $signed({2'b00, v}) + $signed({{2{off[7]}}, off});
      if (s < 10'sd0)
         return 8'h00;
      if (s > 10'sd255)
         return 8'hFF;
      return s[7:0];
   endfunction

   // zero-wait slave: the table read port tracks its index every cycle,
   // so data is current by the access phase
   assign acc = psel_i & penable_i;
   assign wr_acc = acc & pwrite_i;
   assign rd_acc = acc & ~pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~mapped;

   assign fmt = gpp_fmt_t'(st_reg.ctrl[GPP_CTRL_FMT_LO +: 2]);
   assign bypass = st_reg.ctrl[GPP_CTRL_BYPASS_BIT];
   assign vsel = st_reg.ctrl[GPP_CTRL_VSEL_BIT];
   assign vadj = st_reg.ctrl[GPP_CTRL_VADJ_BIT];

   assign tbl_we = wr_acc && paddr_i == GPP_ADR_PAL_DATA && st_reg.wph == GPP_PH_BLUE;
   assign gfx_we = tbl_we & ~vsel;
   assign vid_we = tbl_we & vsel;
   assign wdat[0] = st_reg.hold_r;
   assign wdat[1] = st_reg.hold_g;
   assign wdat[2] = pwdata_i[7:0];

   gpp_fifo #(
      .W(GPP_PIX_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i({pix_video_i, pix_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data),
      .level_o(level)
   );

   for (genvar c = 0; c < 3; c++)
   begin : g_comp
      gpp_tbl #(
         .DW(GPP_COMP_W),
         .DEPTH(GPP_TBL_DEPTH)
      ) u_gfx (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .we_i(gfx_we),
         .waddr_i(st_reg.widx),
         .wdata_i(wdat[c]),
         .caddr_i(st_reg.ridx),
         .cdata_o(cg_q[c]),
         .pen_i(pop),
         .paddr_i(dir[c]),
         .pdata_o(g_q[c])
      );
      gpp_tbl #(
         .DW(GPP_COMP_W),
         .DEPTH(GPP_TBL_DEPTH)
      ) u_vid (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .we_i(vid_we),
         .waddr_i(st_reg.widx),
         .wdata_i(wdat[c]),
         .caddr_i(st_reg.ridx),
         .cdata_o(cv_q[c]),
         .pen_i(pop),
         .paddr_i(dir[c]),
         .pdata_o(v_q[c])
      );
   end

   // index formation for the pixel leaving the fifo
   always_comb
   begin
      dir[0] = f_data[23:16];
      dir[1] = f_data[15:8];
      dir[2] = f_data[7:0];
      if (!f_data[GPP_PIX_W])
      begin
         case (fmt)
            GPP_FMT_8:
            begin
               dir[0] = f_data[7:0];
               dir[1] = f_data[7:0];
               dir[2] = f_data[7:0];
            end
            GPP_FMT_15:
            begin
               dir[0] = {f_data[14:10], f_data[14:12]};
               dir[1] = {f_data[9:5], f_data[9:7]};
               dir[2] = {f_data[4:0], f_data[4:2]};
            end
            GPP_FMT_16:
            begin
               dir[0] = {f_data[15:11], f_data[15:13]};
               dir[1] = {f_data[10:5], f_data[10:9]};
               dir[2] = {f_data[4:0], f_data[4:2]};
            end
            default: ;
         endcase
      end
      // graphics: 8 bpp is always a palette, other formats use gamma unless bypassed; video follows adjust bit 6
      use_tbl = f_data[GPP_PIX_W] ? vadj : (fmt == GPP_FMT_8 || !bypass);
   end

   // output stage: table or direct value, then brightness on video only
   always_comb
   begin
      for (int c = 0; c < 3; c++)
      begin
         base[c] = st_reg.s1_rgb[23-8*c -: 8];
         if (st_reg.s1_use)
            base[c] = st_reg.s1_video ? v_q[c] : g_q[c];
         res[c] = st_reg.s1_video ? gpp_bright(base[c], st_reg.bright) : base[c];
      end
   end

   assign out_adv = ~st_reg.s2_v | dac_ready_i;
   assign s1_load = ~st_reg.s1_v | out_adv;
   assign f_ready = s1_load;
   assign pop = f_valid & s1_load;

   assign dac_valid_o = st_reg.s2_v;
   assign dac_red_o = st_reg.s2_rgb[23:16];
   assign dac_green_o = st_reg.s2_rgb[15:8];
   assign dac_blue_o = st_reg.s2_rgb[7:0];

   always_comb
   begin
      rcomp = 2'd0;
      case (st_reg.rph)
         GPP_PH_GREEN: rcomp = 2'd1;
         GPP_PH_BLUE: rcomp = 2'd2;
         default: rcomp = 2'd0;
      endcase
      status = '0;
      status[GPP_ST_WIDX_LO +: 8] = st_reg.widx;
      status[GPP_ST_RIDX_LO +: 8] = st_reg.ridx;
      status[GPP_ST_LEVEL_LO +: 8] = 8'(level);
      status[GPP_ST_BUSY_BIT] = st_reg.s1_v | st_reg.s2_v;
      mapped = 1'b1;
      prdata_o = '0;
      case (paddr_i)
         GPP_ADR_CTRL: prdata_o = {24'h000000, st_reg.ctrl};
         GPP_ADR_BRIGHT: prdata_o = {24'h000000, st_reg.bright};
         GPP_ADR_STATUS: prdata_o = status;
         GPP_ADR_PAL_RD: prdata_o = {24'h000000, st_reg.ridx};
         GPP_ADR_PAL_WR: prdata_o = {24'h000000, st_reg.widx};
         GPP_ADR_PAL_DATA: prdata_o = {24'h000000, vsel ? cv_q[rcomp] : cg_q[rcomp]};
         default: mapped = 1'b0;
      endcase
      if (!psel_i)
         prdata_o = '0;
   end

   always_comb
   begin
      st_next = st_reg;
      if (wr_acc)
      begin
         case (paddr_i)
            GPP_ADR_CTRL: st_next.ctrl = pwdata_i[7:0];
            GPP_ADR_BRIGHT: st_next.bright = pwdata_i[7:0];
            GPP_ADR_PAL_RD:
            begin
               st_next.ridx = pwdata_i[7:0];
               st_next.rph = GPP_PH_RED;
            end
            GPP_ADR_PAL_WR:
            begin
               st_next.widx = pwdata_i[7:0];
               st_next.wph = GPP_PH_RED;
            end
            GPP_ADR_PAL_DATA:
            begin
               case (st_reg.wph)
                  GPP_PH_RED:
                  begin
                     st_next.hold_r = pwdata_i[7:0];
                     st_next.wph = GPP_PH_GREEN;
                  end
                  GPP_PH_GREEN:
                  begin
                     st_next.hold_g = pwdata_i[7:0];
                     st_next.wph = GPP_PH_BLUE;
                  end
                  GPP_PH_BLUE:
                  begin
                     st_next.widx = st_reg.widx + 8'h01;
                     st_next.wph = GPP_PH_RED;
                  end
                  default: st_next.wph = GPP_PH_RED;
               endcase
            end
            default: ;
         endcase
      end
      if (rd_acc && paddr_i == GPP_ADR_PAL_DATA)
      begin
         case (st_reg.rph)
            GPP_PH_RED: st_next.rph = GPP_PH_GREEN;
            GPP_PH_GREEN: st_next.rph = GPP_PH_BLUE;
            GPP_PH_BLUE:
            begin
               st_next.ridx = st_reg.ridx + 8'h01;
               st_next.rph = GPP_PH_RED;
            end
            default: st_next.rph = GPP_PH_RED;
         endcase
      end
      if (s1_load)
      begin
         st_next.s1_v = f_valid;
         if (f_valid)
         begin
            st_next.s1_video = f_data[GPP_PIX_W];
            st_next.s1_use = use_tbl;
            st_next.s1_rgb = {dir[0], dir[1], dir[2]};
         end
      end
      if (out_adv)
      begin
         st_next.s2_v = st_reg.s1_v;
         if (st_reg.s1_v)
            st_next.s2_rgb = {res[0], res[1], res[2]};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= '0;
         st_reg.ctrl <= GPP_CTRL_RESET;
         st_reg.bright <= GPP_BRIGHT_RESET;
         st_reg.wph <= GPP_PH_RED;
         st_reg.rph <= GPP_PH_RED;
      end
      else
         st_reg <= st_next;
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   chk_bypass_direct: assert property (
      out_adv && st_reg.s1_v && !st_reg.s1_video && !st_reg.s1_use
      |=> dac_valid_o && st_reg.s2_rgb == $past(st_reg.s1_rgb))
      else $error("bypassed pixel was altered");
   chk_pal8_index: assert property (
      pop && !f_data[GPP_PIX_W] && fmt == GPP_FMT_8
      |-> dir[0] == f_data[7:0] && dir[1] == f_data[7:0] && dir[2] == f_data[7:0] && use_tbl)
      else $error("8 bpp index not shared");
   chk_widen_16: assert property (
      pop && !f_data[GPP_PIX_W] && fmt == GPP_FMT_16
      |-> dir[1] == {f_data[10:5], f_data[10:9]} && dir[0][7:3] == f_data[15:11])
      else $error("16 bpp widening wrong");
   chk_true_index: assert property (
      pop && fmt == GPP_FMT_24 |-> {dir[0], dir[1], dir[2]} == f_data[23:0])
      else $error("24 bpp index wrong");
   chk_gfx_lookup: assert property (
      out_adv && st_reg.s1_v && !st_reg.s1_video && st_reg.s1_use
      |=> dac_red_o == $past(g_q[0]) && dac_blue_o == $past(g_q[2]))
      else $error("graphics table not applied");
   chk_video_skip: assert property (
      pop && f_data[GPP_PIX_W] && !vadj ##1 out_adv && st_reg.bright == 8'h00
      |=> dac_green_o == $past(f_data[15:8], 2))
      else $error("video pixel not passed through");
   chk_bright_clamp: assert property (
      out_adv && st_reg.s1_v && st_reg.s1_video && !st_reg.bright[7]
      |=> dac_red_o >= $past(base[0])
      && (dac_red_o == 8'hFF || dac_red_o == $past(base[0]) + $past(st_reg.bright)))
      else $error("brightness wrapped");
   chk_index_advance: assert property (
      wr_acc && paddr_i == GPP_ADR_PAL_DATA && st_reg.wph == GPP_PH_BLUE
      |=> st_reg.widx == $past(st_reg.widx) + 8'h01 && st_reg.wph == GPP_PH_RED)
      else $error("palette index did not step after blue");
   chk_vsel_route: assert property (
      tbl_we |-> (vid_we == vsel) && (gfx_we == !vsel))
      else $error("palette write misrouted");
endmodule

// file: rtl/gpp_pkg.sv
package gpp_pkg;
   // printed palette port numbers are word indices; byte address is four times the index
   localparam logic [11:0] GPP_IDX_PAL_RD = 12'h3C7;
   localparam logic [11:0] GPP_IDX_PAL_WR = 12'h3C8;
   localparam logic [11:0] GPP_IDX_PAL_DATA = 12'h3C9;
   localparam logic [11:0] GPP_ADR_PAL_RD = {GPP_IDX_PAL_RD[9:0], 2'b00};
   localparam logic [11:0] GPP_ADR_PAL_WR = {GPP_IDX_PAL_WR[9:0], 2'b00};
   localparam logic [11:0] GPP_ADR_PAL_DATA = {GPP_IDX_PAL_DATA[9:0], 2'b00};
   localparam logic [11:0] GPP_ADR_CTRL = 12'h000;
   localparam logic [11:0] GPP_ADR_BRIGHT = 12'h004;
   localparam logic [11:0] GPP_ADR_STATUS = 12'h008;
   // control register fields
   localparam int GPP_CTRL_FMT_LO = 0;
   localparam int GPP_CTRL_VSEL_BIT = 4;
   localparam int GPP_CTRL_VADJ_BIT = 6;
   localparam int GPP_CTRL_BYPASS_BIT = 7;
   localparam logic [7:0] GPP_CTRL_RESET = 8'h00;
   localparam logic [7:0] GPP_BRIGHT_RESET = 8'h00;
   // status register fields
   localparam int GPP_ST_WIDX_LO = 0;
   localparam int GPP_ST_RIDX_LO = 8;
   localparam int GPP_ST_LEVEL_LO = 16;
   localparam int GPP_ST_BUSY_BIT = 24;
   // geometry
   localparam int GPP_PIX_W = 24;
   localparam int GPP_FIFO_DEPTH = 8;
   localparam int GPP_TBL_DEPTH = 256;
   localparam int GPP_COMP_W = 8;
   typedef enum logic [1:0] {
      GPP_FMT_8 = 2'h0,
      GPP_FMT_15 = 2'h1,
      GPP_FMT_16 = 2'h2,
      GPP_FMT_24 = 2'h3
   } gpp_fmt_t;
   // gray sequence red -> green -> blue
   typedef enum logic [1:0] {
      GPP_PH_RED = 2'h0,
      GPP_PH_GREEN = 2'h1,
      GPP_PH_BLUE = 2'h3
   } gpp_phase_t;
endpackage

// file: rtl/gpp_fifo.sv
`timescale 1ns/1ps
module gpp_fifo
   import gpp_pkg::*;
#(
   parameter int W = GPP_PIX_W + 1,
   parameter int DEPTH = GPP_FIFO_DEPTH,
   localparam int AW = $clog2(DEPTH)
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic [AW:0] level_o
);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } gpp_fifo_st_t;
   gpp_fifo_st_t st_reg, st_next;
   logic [W-1:0] mem [DEPTH];
   logic push, pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("gpp_fifo: DEPTH must be a power of two, at least 2");
   end

   assign level_o = st_reg.wp - st_reg.rp;
   assign in_ready_o = level_o != (AW+1)'(DEPTH);
   assign out_valid_o = st_reg.wp != st_reg.rp;
   assign out_data_o = mem[st_reg.rp[AW-1:0]];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      st_next = st_reg;
      if (push)
         st_next.wp = st_reg.wp + 1'b1;
      if (pop)
         st_next.rp = st_reg.rp + 1'b1;
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   always_ff @(posedge clock_i)
   begin
      if (push)
         mem[st_reg.wp[AW-1:0]] <= in_data_i;
   end

   chk_fifo_level_step: assert property (@(posedge clock_i) disable iff (rst_i)
      push && !pop |=> level_o == $past(level_o) + 1'b1)
      else $error("fifo level did not rise on push");
endmodule

// file: rtl/gpp_tbl.sv
`timescale 1ns/1ps
module gpp_tbl
#(
   parameter int DW = 8,
   parameter int DEPTH = 256,
   localparam int AW = $clog2(DEPTH)
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // software port: write, and a read that follows its address every cycle
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] caddr_i,
   output logic [DW-1:0] cdata_o,
   // pixel port: read held while the pipeline stalls
   input wire logic pen_i,
   input wire logic [AW-1:0] paddr_i,
   output logic [DW-1:0] pdata_o
);
   logic [DW-1:0] mem [DEPTH];

   if (DEPTH < 2 || DW < 1)
   begin : g_chk
      $error("gpp_tbl: bad geometry");
   end

   always_ff @(posedge clock_i)
   begin
      if (we_i)
         mem[waddr_i] <= wdata_i;
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cdata_o <= '0;
         pdata_o <= '0;
      end
      else
      begin
         cdata_o <= mem[caddr_i];
         if (pen_i)
            pdata_o <= mem[paddr_i];
      end
   end
endmodule

// file: bench/gpp_path_tb.sv
`timescale 1ns/1ps
module gpp_path_tb
   import gpp_pkg::*;
;
   localparam int LIMIT = 20000;
   localparam int FD = GPP_FIFO_DEPTH;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pix_valid = 1'b0;
   logic pix_ready;
   logic [23:0] pix_data = 24'h0;
   logic pix_video = 1'b0;
   logic dac_valid;
   logic dac_ready = 1'b1;
   logic [7:0] dac_r;
   logic [7:0] dac_g;
   logic [7:0] dac_b;
   logic [31:0] rq;
   logic re;
   logic [7:0] ctrl_m = 8'h00;
   logic [7:0] bright_m = 8'h00;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   logic [23:0] pix [4] = '{24'h000000, 24'hFFFFFF, 24'h12A5F0, 24'h7F8001};
   logic [7:0] brt [5] = '{8'h00, 8'h40, 8'hC0, 8'h7F, 8'h80};

   gpp_path #(.FIFO_DEPTH(FD)) DUT (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pix_valid_i(pix_valid), .pix_ready_o(pix_ready), .pix_data_i(pix_data),
      .pix_video_i(pix_video), .dac_valid_o(dac_valid), .dac_ready_i(dac_ready), .dac_red_o(dac_r),
      .dac_green_o(dac_g), .dac_blue_o(dac_b));

   always #12.5 clock_i = ~clock_i;

   task automatic wrap_up;
      if (fails == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails++;
         wrap_up;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // table contents chosen so that no entry maps a value onto itself in the graphics set
   function automatic logic [7:0] tv(input logic v, input int c, input logic [7:0] i);
      case ({v, c[1:0]})
         3'b000: return i ^ 8'h5A;
         3'b001: return i + 8'h33;
         3'b010: return ~i;
         3'b100: return {i[3:0], i[7:4]};
         3'b101: return i ^ 8'hC3;
         default: return i - 8'h10;
      endcase
   endfunction

   function automatic logic [7:0] sat(input logic [7:0] x);
      int s;
      s = int'(x) + int'($signed(bright_m));
      if (s > 255)
         return 8'hFF;
      if (s < 0)
         return 8'h00;
      return 8'(s);
   endfunction

   function automatic logic [23:0] model(input logic [23:0] p, input logic v);
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      r = p[23:16];
      g = p[15:8];
      b = p[7:0];
      if (v)
      begin
         if (ctrl_m[6])
         begin
            r = tv(1'b1, 0, r);
            g = tv(1'b1, 1, g);
            b = tv(1'b1, 2, b);
         end
         return {sat(r), sat(g), sat(b)};
      end
      if (ctrl_m[1:0] == 2'h0)
         return {tv(1'b0, 0, p[7:0]), tv(1'b0, 1, p[7:0]), tv(1'b0, 2, p[7:0])};
      if (ctrl_m[1:0] == 2'h1)
         {r, g, b} = {p[14:10], p[14:12], p[9:5], p[9:7], p[4:0], p[4:2]};
      if (ctrl_m[1:0] == 2'h2)
         {r, g, b} = {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
      if (ctrl_m[7])
         return {r, g, b};
      return {tv(1'b0, 0, r), tv(1'b0, 1, g), tv(1'b0, 2, b)};
   endfunction

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // the access lasts until pready is seen high at a rising edge; if it never is, only the cycle limit ends the wait
      do
         @(posedge clock_i);
      while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_ctrl(input logic [7:0] c);
      ctrl_m = c;
      apb(1'b1, GPP_ADR_CTRL, {24'h0, c});
   endtask

   task automatic set_bright(input logic [7:0] c);
      bright_m = c;
      apb(1'b1, GPP_ADR_BRIGHT, {24'h0, c});
   endtask

   task automatic pix_send(input logic [23:0] p, input logic v);
      @(posedge clock_i);
      pix_valid <= 1'b1;
      pix_data <= p;
      pix_video <= v;
      @(negedge clock_i);
      while (pix_ready !== 1'b1)
         @(negedge clock_i);
      @(posedge clock_i);
      pix_valid <= 1'b0;
   endtask

   task automatic get_out(input logic [23:0] exp);
      int n;
      n = 0;
      do
      begin
         @(negedge clock_i);
         n++;
      end
      while (dac_valid !== 1'b1 && n < 32);
      check("dac valid", {31'h0, dac_valid}, 32'h1);
      check("dac colour", {8'h00, dac_r, dac_g, dac_b}, {8'h00, exp});
      @(posedge clock_i);
   endtask

   task automatic sc_regs;
      apb(1'b0, GPP_ADR_CTRL, 32'h0);
      check("control reset", rq, {24'h0, GPP_CTRL_RESET});
      apb(1'b0, GPP_ADR_BRIGHT, 32'h0);
      check("brightness reset", rq, {24'h0, GPP_BRIGHT_RESET});
      apb(1'b0, GPP_ADR_STATUS, 32'h0);
      check("status reset", rq, 32'h0);
      set_bright(8'h5A);
      apb(1'b0, GPP_ADR_BRIGHT, 32'h0);
      check("brightness rw", rq, 32'h0000005A);
      apb(1'b1, 12'h00C, 32'h000000FF);
      check("unmapped write error", {31'h0, re}, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      check("unmapped read error", {31'h0, re}, 32'h1);
      check("unmapped read data", rq, 32'h0);
      set_bright(8'h00);
   endtask

   task automatic load(input logic v);
      set_ctrl({3'h0, v, 4'h0});
      apb(1'b1, GPP_ADR_PAL_WR, 32'h0);
      for (int i = 0; i < GPP_TBL_DEPTH; i++)
         for (int c = 0; c < 3; c++)
            apb(1'b1, GPP_ADR_PAL_DATA, {24'h0, tv(v, c, i[7:0])});
   endtask

   task automatic readback(input logic v, input logic [7:0] idx);
      set_ctrl({3'h0, v, 4'h0});
      apb(1'b1, GPP_ADR_PAL_RD, {24'h0, idx});
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b0, GPP_ADR_PAL_DATA, 32'h0);
         check("palette entry", rq, {24'h0, tv(v, k % 3, idx + 8'(k / 3))});
      end
   endtask

   task automatic sc_palette;
      load(1'b0);
      load(1'b1);
      readback(1'b0, 8'hFF);
      readback(1'b1, 8'hFF);
      // an index write in mid-triple must drop the half-written entry
      set_ctrl(8'h00);
      apb(1'b1, GPP_ADR_PAL_WR, 32'h40);
      apb(1'b1, GPP_ADR_PAL_DATA, 32'h0);
      apb(1'b1, GPP_ADR_PAL_DATA, 32'h0);
      apb(1'b1, GPP_ADR_PAL_WR, 32'h40);
      for (int c = 0; c < 5; c++)
         apb(1'b1, GPP_ADR_PAL_DATA, {24'h0, tv(1'b0, c % 3, 8'h40 + 8'(c / 3))});
      readback(1'b0, 8'h40);
      readback(1'b1, 8'h40);
   endtask

   task automatic sc_formats;
      for (int m = 0; m < 8; m++)
      begin
         set_ctrl({m[2], 5'h0, m[1:0]});
         foreach (pix[k])
         begin
            pix_send(pix[k], 1'b0);
            get_out(model(pix[k], 1'b0));
         end
      end
   endtask

   task automatic sc_video;
      for (int a = 0; a < 2; a++)
         for (int b = 0; b < 5; b++)
         begin
            set_ctrl({1'b0, a[0], 4'h0, 2'h3});
            set_bright(brt[b]);
            foreach (pix[k])
            begin
               pix_send(pix[k], 1'b1);
               get_out(model(pix[k], 1'b1));
               pix_send(pix[k], 1'b0);
               get_out(model(pix[k], 1'b0));
            end
         end
      set_bright(8'h00);
   endtask

   task automatic sc_fill;
      int n;
      logic r;
      set_ctrl(8'h83);
      dac_ready <= 1'b0;
      @(posedge clock_i);
      pix_valid <= 1'b1;
      pix_video <= 1'b0;
      pix_data <= 24'h0;
      n = 0;
      repeat (16)
      begin
         @(negedge clock_i);
         r = pix_ready;
         @(posedge clock_i);
         if (r === 1'b1)
            n++;
         pix_data <= 24'(n) * 24'h030507;
      end
      pix_valid <= 1'b0;
      check("pixels accepted while stalled", 32'(n), 32'(FD + 2));
      apb(1'b0, GPP_ADR_STATUS, 32'h0);
      check("status full", rq & 32'h01FF0000, {7'h0, 1'b1, 8'(FD), 16'h0});
      dac_ready <= 1'b1;
      for (int k = 0; k < n; k++)
         get_out(24'(k) * 24'h030507);
      apb(1'b0, GPP_ADR_STATUS, 32'h0);
      check("status drained", rq & 32'h01FF0000, 32'h0);
   endtask

   initial
   begin
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      sc_regs;
      sc_palette;
      sc_formats;
      sc_video;
      sc_fill;
      wrap_up;
   end
endmodule
